// >>> src/pbes_pkg.sv
/*
  Constants shared by the power backup enable sequencer: register offsets,
  field positions, reset values, serial slave address and timing counts.
  Assumes a 250 MHz core clock.
*/
package pbes_pkg;

  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] PBES_OFF_CHARGE_CONTROL_ONE = 8'h06;
  localparam logic [7:0] PBES_OFF_CHARGE_CONTROL_TWO = 8'h07;
  localparam logic [7:0] PBES_OFF_RELEASE_CONTROL_TWO = 8'h09;
  localparam logic [7:0] PBES_OFF_SYSTEM_CONTROL_TWO = 8'h41;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int PBES_BIT_CHARGE_ENABLE = 0;
  localparam int PBES_BIT_PATH_ISOLATE = 0;
  localparam int PBES_BIT_FAST_DISCHARGE_EN = 0;
  localparam int PBES_BIT_CHARGE_DISCHARGE_EN = 0;
  localparam int PBES_BIT_FUSE_ONE_EN = 1;
  localparam int PBES_BIT_FUSE_TWO_EN = 2;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0] PBES_RST_CHARGE_CONTROL_ONE = 8'h00;
  localparam logic [7:0] PBES_RST_CHARGE_CONTROL_TWO = 8'h00;
  localparam logic [7:0] PBES_RST_RELEASE_CONTROL_TWO = 8'h00;
  localparam logic [7:0] PBES_RST_SYSTEM_CONTROL_TWO = 8'h06;

  // ------------------------------------------------------------
  // Serial interface
  // ------------------------------------------------------------
  // Slave address, value arbitrary
  localparam logic [6:0] PBES_SLAVE_ADDR = 7'h2A;
  localparam logic [3:0] PBES_BITS_PER_BYTE = 4'h8;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int PBES_CLK_MHZ = 250;
  localparam int PBES_DEGLITCH_TIME_US = 1000;
  localparam int PBES_DEGLITCH_CYCLES = PBES_DEGLITCH_TIME_US * PBES_CLK_MHZ;
  localparam int PBES_DEGLITCH_W = 18;

endpackage : pbes_pkg

// >>> src/pbes_top.sv
/*
  Enable and mode sequencing of a power loss protection manager: fuse
  gating, profile selection, charge and release control, storage discharge,
  downstream enable and power-disable deglitch, with a serial register slave.
  Assumes analog comparators and soft start flags arrive asynchronously and
  that the reset is released when the internal supply is valid.
*/
`timescale 1ns/10ps

// Operation
// - A fuse is on only with enable pin high and its enable bit set.
// - Enable pin low forces both fuses off and, with charge enable set, starts buck release.
// - Profile pin high: both fuses switch together once both inputs pass lockout.
// - Dual profile charging needs fuses on, both detects ok, feedback ok.
// - Profile pin low: first fuse turns on once first input passes lockout.
// - Single profile charging uses first fuse and first detect; only it triggers backup.
// - Dual profile releases when either detect input signals power loss.
// - Charge enable set enables converter; charging starts once thresholds pass.
// - Charge enable clear stops charging and blocks buck release on loss.
// - Charge enable clear turns off blocking transistor and converter switching.
// - Fast discharge needs enable, no isolate, charge-discharge enable, above 2.9V, no charge.
// - Fast discharge turns on the current sink and the discharge transistor.
// - Fast discharge ends when any of its conditions fails.
// - Setting charge enable above 2.9V stops fast discharge and resumes charging.
// - Supply loss resets the serial logic and clears charge enable.
// - Discharge transistor stays on whenever charge enable is clear.
// - Resistor discharge needs no fast enable, isolate, charge-discharge enable, no charge.
// - Downstream enable rises after soft start of the fuses of the profile.
// - Downstream enable falls once buck release has finished.
// - Power-disable pins are deglitched; changes shorter than 1ms are ignored.
module pbes_top #(
  parameter int DEGLITCH_CYCLES = pbes_pkg::PBES_DEGLITCH_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire logic fuse_enable_pin_i,
  input wire logic profile_select_pin_i,
  input wire logic uvlo_ok_one_i,
  input wire logic uvlo_ok_two_i,
  input wire logic loss_detect_one_ok_i,
  input wire logic loss_detect_two_ok_i,
  input wire logic release_feedback_ok_i,
  input wire logic storage_above_min_i,
  input wire logic release_done_i,
  input wire logic soft_start_done_one_i,
  input wire logic soft_start_done_two_i,
  input wire logic power_disable_a_i,
  input wire logic power_disable_b_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic fuse_one_on_o,
  output logic fuse_two_on_o,
  output logic boost_charge_o,
  output logic buck_release_o,
  output logic blocking_fet_node_on_o,
  output logic storage_converter_en_o,
  output logic fast_sink_on_o,
  output logic discharge_transistor_on_o,
  output logic resistor_discharge_o,
  output logic downstream_enable_out_o
);

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  localparam int NSYNC = 15;

  typedef enum logic [3:0] {
    PBES_ST_IDLE = 4'h0,
    PBES_ST_ADDR = 4'h1,
    PBES_ST_ACK_ADDR = 4'h2,
    PBES_ST_REG = 4'h3,
    PBES_ST_ACK_REG = 4'h4,
    PBES_ST_WDATA = 4'h5,
    PBES_ST_ACK_WDATA = 4'h6,
    PBES_ST_RDATA = 4'h7,
    PBES_ST_RACK = 4'h8
  } pbes_i2c_e;

  logic [NSYNC-1:0] async_in;
  logic [NSYNC-1:0] filt;
  logic en_pin;
  logic dual;
  logic uvlo1;
  logic uvlo2;
  logic lok1;
  logic lok2;
  logic rfb_ok;
  logic above_min;
  logic rel_done;
  logic ss1;
  logic ss2;
  logic pd_a_raw;
  logic pd_b_raw;
  logic scl_f;
  logic sda_f;

  assign async_in = {fuse_enable_pin_i, profile_select_pin_i, uvlo_ok_one_i, uvlo_ok_two_i,
                     loss_detect_one_ok_i, loss_detect_two_ok_i, release_feedback_ok_i,
                     storage_above_min_i, release_done_i, soft_start_done_one_i,
                     soft_start_done_two_i, power_disable_a_i, power_disable_b_i,
                     scl_i, sda_i};
  assign {en_pin, dual, uvlo1, uvlo2, lok1, lok2, rfb_ok, above_min, rel_done, ss1, ss2,
          pd_a_raw, pd_b_raw, scl_f, sda_f} = filt;

  // Three stages; the filtered level moves only when stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      logic f_reg;
      always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
          s3_reg <= 1'b0;
          f_reg <= 1'b0;
        end else if (ce_i) begin
          s1_reg <= async_in[gi];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          if (s2_reg == s3_reg) begin
            f_reg <= s3_reg;
          end
        end
      end
      assign filt[gi] = f_reg;
    end
  endgenerate

  // ------------------------------------------------------------
  // Power-disable deglitch
  // ------------------------------------------------------------
  localparam logic [pbes_pkg::PBES_DEGLITCH_W-1:0] DEG_LAST =
    pbes_pkg::PBES_DEGLITCH_W'(DEGLITCH_CYCLES - 1);

  logic [1:0] pd_raw;
  logic [1:0] pd_db;

  assign pd_raw = {pd_a_raw, pd_b_raw};

  // A level is taken only after it has stood for the whole deglitch time
  generate
    for (gi = 0; gi < 2; gi++) begin : g_deg
      logic [pbes_pkg::PBES_DEGLITCH_W-1:0] cnt_reg;
      logic db_reg;
      always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          cnt_reg <= '0;
          db_reg <= 1'b0;
        end else if (ce_i) begin
          if (pd_raw[gi] == db_reg) begin
            cnt_reg <= '0;
          end else if (cnt_reg == DEG_LAST) begin
            cnt_reg <= '0;
            db_reg <= pd_raw[gi];
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
      end
      assign pd_db[gi] = db_reg;
    end
  endgenerate

  // ------------------------------------------------------------
  // Serial register slave
  // ------------------------------------------------------------
  pbes_i2c_e st_reg;
  logic scl_d_reg;
  logic sda_d_reg;
  logic [7:0] sr_reg;
  logic [3:0] cnt_reg;
  logic [7:0] ptr_reg;
  logic nack_reg;
  logic wr_reg;
  logic [7:0] wdata_reg;
  logic [7:0] waddr_reg;
  logic [7:0] rd_data;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic byte_done;
  logic addr_match;

  // Bus condition detection on the filtered pins
  assign scl_rise = scl_f & ~scl_d_reg;
  assign scl_fall = ~scl_f & scl_d_reg;
  assign bus_start = scl_f & scl_d_reg & sda_d_reg & ~sda_f;
  assign bus_stop = scl_f & scl_d_reg & ~sda_d_reg & sda_f;
  assign byte_done = (cnt_reg == pbes_pkg::PBES_BITS_PER_BYTE);
  assign addr_match = (sr_reg[7:1] == pbes_pkg::PBES_SLAVE_ADDR);

  // Byte-level slave: address, register pointer, then data with auto increment
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_reg <= PBES_ST_IDLE;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      sr_reg <= 8'h00;
      cnt_reg <= 4'h0;
      ptr_reg <= 8'h00;
      nack_reg <= 1'b0;
      wr_reg <= 1'b0;
      wdata_reg <= 8'h00;
      waddr_reg <= 8'h00;
      sda_oe_o <= 1'b0;
      sda_o <= 1'b0;
    end else if (ce_i) begin
      scl_d_reg <= scl_f;
      sda_d_reg <= sda_f;
      wr_reg <= 1'b0;
      if (bus_start) begin
        st_reg <= PBES_ST_ADDR;
        cnt_reg <= 4'h0;
        sda_oe_o <= 1'b0;
      end else if (bus_stop) begin
        st_reg <= PBES_ST_IDLE;
        sda_oe_o <= 1'b0;
      end else if (scl_rise) begin
        cnt_reg <= cnt_reg + 1'b1;
        if (st_reg == PBES_ST_RACK) begin
          nack_reg <= sda_f;
        end else if ((st_reg != PBES_ST_RDATA) && !byte_done) begin // Skip the ack slot
          sr_reg <= {sr_reg[6:0], sda_f};
        end
      end else if (scl_fall) begin
        case (st_reg)
          PBES_ST_ADDR: begin
            if (byte_done) begin
              st_reg <= addr_match ? PBES_ST_ACK_ADDR : PBES_ST_IDLE;
              sda_oe_o <= addr_match;
            end
          end
          PBES_ST_REG: begin
            if (byte_done) begin
              ptr_reg <= sr_reg;
              st_reg <= PBES_ST_ACK_REG;
              sda_oe_o <= 1'b1;
            end
          end
          PBES_ST_WDATA: begin
            if (byte_done) begin
              wr_reg <= 1'b1;
              waddr_reg <= ptr_reg;
              wdata_reg <= sr_reg;
              ptr_reg <= ptr_reg + 1'b1;
              st_reg <= PBES_ST_ACK_WDATA;
              sda_oe_o <= 1'b1;
            end
          end
          PBES_ST_ACK_ADDR: begin
            cnt_reg <= 4'h0;
            if (sr_reg[0]) begin
              sr_reg <= rd_data;
              ptr_reg <= ptr_reg + 1'b1;
              sda_oe_o <= ~rd_data[7];
              st_reg <= PBES_ST_RDATA;
            end else begin
              sda_oe_o <= 1'b0;
              st_reg <= PBES_ST_REG;
            end
          end
          PBES_ST_ACK_REG, PBES_ST_ACK_WDATA: begin
            cnt_reg <= 4'h0;
            sda_oe_o <= 1'b0;
            st_reg <= PBES_ST_WDATA;
          end
          PBES_ST_RDATA: begin
            if (byte_done) begin
              sda_oe_o <= 1'b0;
              st_reg <= PBES_ST_RACK;
            end else begin
              sr_reg <= {sr_reg[6:0], 1'b0};
              sda_oe_o <= ~sr_reg[6];
            end
          end
          PBES_ST_RACK: begin
            cnt_reg <= 4'h0;
            if (nack_reg) begin
              st_reg <= PBES_ST_IDLE;
            end else begin
              sr_reg <= rd_data;
              ptr_reg <= ptr_reg + 1'b1;
              sda_oe_o <= ~rd_data[7];
              st_reg <= PBES_ST_RDATA;
            end
          end
          default: begin
            st_reg <= PBES_ST_IDLE;
            sda_oe_o <= 1'b0;
          end
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------
  logic [7:0] cc1_reg;
  logic [7:0] cc2_reg;
  logic [7:0] rc2_reg;
  logic [7:0] sc2_reg;
  logic wr_cc1;
  logic wr_cc2;
  logic wr_rc2;
  logic wr_sc2;

  // Write decode and read selection; unmapped offsets read as zero
  assign wr_cc1 = wr_reg & (waddr_reg == pbes_pkg::PBES_OFF_CHARGE_CONTROL_ONE);
  assign wr_cc2 = wr_reg & (waddr_reg == pbes_pkg::PBES_OFF_CHARGE_CONTROL_TWO);
  assign wr_rc2 = wr_reg & (waddr_reg == pbes_pkg::PBES_OFF_RELEASE_CONTROL_TWO);
  assign wr_sc2 = wr_reg & (waddr_reg == pbes_pkg::PBES_OFF_SYSTEM_CONTROL_TWO);
  assign rd_data = (ptr_reg == pbes_pkg::PBES_OFF_CHARGE_CONTROL_ONE) ? cc1_reg :
                   (ptr_reg == pbes_pkg::PBES_OFF_CHARGE_CONTROL_TWO) ? cc2_reg :
                   (ptr_reg == pbes_pkg::PBES_OFF_RELEASE_CONTROL_TWO) ? rc2_reg :
                   (ptr_reg == pbes_pkg::PBES_OFF_SYSTEM_CONTROL_TWO) ? sc2_reg : 8'h00;

  // Supply loss clears charge enable; host must write it again
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cc1_reg <= pbes_pkg::PBES_RST_CHARGE_CONTROL_ONE;
      cc2_reg <= pbes_pkg::PBES_RST_CHARGE_CONTROL_TWO;
      rc2_reg <= pbes_pkg::PBES_RST_RELEASE_CONTROL_TWO;
      sc2_reg <= pbes_pkg::PBES_RST_SYSTEM_CONTROL_TWO;
    end else if (ce_i) begin
      if (wr_cc1) cc1_reg <= wdata_reg;
      if (wr_cc2) cc2_reg <= wdata_reg;
      if (wr_rc2) rc2_reg <= wdata_reg;
      if (wr_sc2) sc2_reg <= wdata_reg;
    end
  end

  // ------------------------------------------------------------
  // Sequencing logic
  // ------------------------------------------------------------
  logic chg_en;
  logic iso;
  logic fast_en;
  logic cd_en;
  logic pd_allow;
  logic gate1;
  logic gate2;
  logic fuse1_next;
  logic fuse2_next;
  logic loss;
  logic release_next;
  logic boost_next;
  logic fast_next;
  logic res_next;
  logic ss_ok;
  logic ds_next;

  assign chg_en = cc1_reg[pbes_pkg::PBES_BIT_CHARGE_ENABLE];
  assign iso = cc2_reg[pbes_pkg::PBES_BIT_PATH_ISOLATE];
  assign fast_en = rc2_reg[pbes_pkg::PBES_BIT_FAST_DISCHARGE_EN];
  assign cd_en = sc2_reg[pbes_pkg::PBES_BIT_CHARGE_DISCHARGE_EN];

  // Fuses off only for disable-a low with disable-b high
  assign pd_allow = ~(~pd_db[1] & pd_db[0]);
  assign gate1 = en_pin & sc2_reg[pbes_pkg::PBES_BIT_FUSE_ONE_EN] & pd_allow;
  assign gate2 = en_pin & sc2_reg[pbes_pkg::PBES_BIT_FUSE_TWO_EN] & pd_allow;
  assign fuse1_next = dual ? (gate1 & gate2 & uvlo1 & uvlo2) : (gate1 & uvlo1);
  assign fuse2_next = dual & gate1 & gate2 & uvlo1 & uvlo2;

  // Power loss per profile, and release held until stored energy is spent
  assign loss = dual ? (~lok1 | ~lok2) : ~lok1;
  assign release_next = ~chg_en ? 1'b0 :
                        (buck_release_o & rel_done) ? 1'b0 :
                        ((~en_pin | loss) & ~rel_done) ? 1'b1 : buck_release_o;
  assign boost_next = chg_en & ~buck_release_o & rfb_ok &
                      (dual ? (fuse_one_on_o & fuse_two_on_o & lok1 & lok2)
                            : (fuse_one_on_o & lok1));

  // Discharge condition sets, evaluated every cycle
  assign fast_next = fast_en & ~iso & cd_en & above_min & ~chg_en;
  assign res_next = ~fast_en & iso & cd_en & ~chg_en;

  // Downstream enable follows soft start of the profile's fuses
  assign ss_ok = dual ? (ss1 & ss2 & fuse_one_on_o & fuse_two_on_o) : (ss1 & fuse_one_on_o);
  assign ds_next = (buck_release_o & rel_done) ? 1'b0 :
                   (ss_ok & ~buck_release_o) ? 1'b1 : downstream_enable_out_o;

  // Registered outputs
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fuse_one_on_o <= 1'b0;
      fuse_two_on_o <= 1'b0;
      boost_charge_o <= 1'b0;
      buck_release_o <= 1'b0;
      blocking_fet_node_on_o <= 1'b0;
      storage_converter_en_o <= 1'b0;
      fast_sink_on_o <= 1'b0;
      discharge_transistor_on_o <= 1'b1;
      resistor_discharge_o <= 1'b0;
      downstream_enable_out_o <= 1'b0;
    end else if (ce_i) begin
      fuse_one_on_o <= fuse1_next;
      fuse_two_on_o <= fuse2_next;
      boost_charge_o <= boost_next;
      buck_release_o <= release_next;
      blocking_fet_node_on_o <= chg_en;
      storage_converter_en_o <= chg_en;
      fast_sink_on_o <= fast_next;
      discharge_transistor_on_o <= fast_next | ~chg_en;
      resistor_discharge_o <= res_next;
      downstream_enable_out_o <= ds_next;
    end
  end

endmodule : pbes_top

// >>> verification/pbes_sva.sv
/*
  Checker for the enable sequencer outputs, bound to pbes_top.
  Assumes one clock domain and the asynchronous active-low reset.
*/
`timescale 1ns/10ps
module pbes_sva #(
  parameter int DEGLITCH_CYCLES = pbes_pkg::PBES_DEGLITCH_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic fuse_enable_pin_i,
  input wire logic profile_select_pin_i,
  input wire logic uvlo_ok_two_i,
  input wire logic storage_above_min_i,
  input wire logic fuse_one_on_o,
  input wire logic fuse_two_on_o,
  input wire logic boost_charge_o,
  input wire logic buck_release_o,
  input wire logic blocking_fet_node_on_o,
  input wire logic storage_converter_en_o,
  input wire logic fast_sink_on_o,
  input wire logic discharge_transistor_on_o,
  input wire logic resistor_discharge_o,
  input wire logic downstream_enable_out_o
);
  // ------------------------------------------------------------
  // Output relations
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  // Eight cycles cover the pin synchroniser and the output register
  AST_FUSE_PIN_LOW: assert property (
    (!fuse_enable_pin_i)[*8] |=> !fuse_one_on_o && !fuse_two_on_o)
    else $error("Fuse on while enable pin low");
  AST_DUAL_LOCKOUT: assert property (
    (profile_select_pin_i && !uvlo_ok_two_i)[*8] |=> !fuse_one_on_o)
    else $error("Dual profile fuse on below lockout");
  AST_DUAL_TOGETHER: assert property (
    profile_select_pin_i[*8] |=> fuse_one_on_o == fuse_two_on_o)
    else $error("Dual profile fuses differ");
  AST_SINGLE_FUSE_TWO: assert property (
    (!profile_select_pin_i)[*8] |=> !fuse_two_on_o)
    else $error("Second fuse on in single profile");
  AST_BLOCK_WITH_CONV: assert property (
    blocking_fet_node_on_o == storage_converter_en_o)
    else $error("Blocking transistor and converter disagree");
  AST_CHARGE_OFF: assert property (
    (!storage_converter_en_o)[*2] |->
      !boost_charge_o && !buck_release_o && discharge_transistor_on_o)
    else $error("Activity with charge disabled");
  AST_CHARGE_ON: assert property (
    storage_converter_en_o[*2] |-> !fast_sink_on_o && !resistor_discharge_o)
    else $error("Discharge while charge enabled");
  AST_FAST_BELOW_MIN: assert property (
    (!storage_above_min_i)[*8] |=> !fast_sink_on_o)
    else $error("Fast discharge below minimum");
  AST_FAST_PATH: assert property (
    fast_sink_on_o |-> discharge_transistor_on_o && !resistor_discharge_o)
    else $error("Fast sink without discharge transistor");
  AST_DS_RISE: assert property (
    $rose(downstream_enable_out_o) |-> $past(fuse_one_on_o) && !$past(buck_release_o))
    else $error("Downstream enable rose early");
  AST_DS_FALL: assert property (
    $fell(downstream_enable_out_o) |-> $past(buck_release_o))
    else $error("Downstream enable fell outside release");
endmodule : pbes_sva

// Attach to every sequencer instance
bind pbes_top pbes_sva #(.DEGLITCH_CYCLES(DEGLITCH_CYCLES)) i_sva (
  .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .fuse_enable_pin_i(fuse_enable_pin_i),
  .profile_select_pin_i(profile_select_pin_i), .uvlo_ok_two_i(uvlo_ok_two_i),
  .storage_above_min_i(storage_above_min_i), .fuse_one_on_o(fuse_one_on_o),
  .fuse_two_on_o(fuse_two_on_o), .boost_charge_o(boost_charge_o),
  .buck_release_o(buck_release_o), .blocking_fet_node_on_o(blocking_fet_node_on_o),
  .storage_converter_en_o(storage_converter_en_o), .fast_sink_on_o(fast_sink_on_o),
  .discharge_transistor_on_o(discharge_transistor_on_o),
  .resistor_discharge_o(resistor_discharge_o),
  .downstream_enable_out_o(downstream_enable_out_o)
);

// >>> verification/pbes_host_model.sv
/*
  Host controller model: serial master for register writes and reads.
  Assumes the line is open drain with a pull-up and phases of 10 cycles.
*/
`timescale 1ns/10ps
module pbes_host_model (
  input wire logic core_clk_i,
  input wire logic sda_oe_i,
  output logic scl_o,
  output logic sda_o
);
  logic sda_drv;

  // Wired-and data line, released level is high
  assign sda_o = sda_drv & ~sda_oe_i;

  initial begin
    scl_o = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask : hold

  // Start, also used as repeated start
  task automatic start_cond();
    hold(1);
    sda_drv <= 1'b1;
    hold(10);
    scl_o <= 1'b1;
    hold(10);
    sda_drv <= 1'b0;
    hold(10);
    scl_o <= 1'b0;
    hold(10);
  endtask : start_cond

  task automatic stop_cond();
    sda_drv <= 1'b0;
    hold(10);
    scl_o <= 1'b1;
    hold(10);
    sda_drv <= 1'b1;
    hold(10);
  endtask : stop_cond

  // Data changes only while the clock is low
  task automatic put_bit(input logic b);
    sda_drv <= b;
    hold(10);
    scl_o <= 1'b1;
    hold(10);
    scl_o <= 1'b0;
    hold(10);
  endtask : put_bit

  task automatic get_bit(output logic b);
    sda_drv <= 1'b1;
    hold(10);
    scl_o <= 1'b1;
    hold(5);
    b = sda_o;
    hold(5);
    scl_o <= 1'b0;
    hold(10);
  endtask : get_bit

  // Byte out most significant bit first, then the acknowledge slot
  task automatic put_byte(input logic [7:0] d);
    logic ack;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i]);
    end
    get_bit(ack);
  endtask : put_byte

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    start_cond();
    put_byte({pbes_pkg::PBES_SLAVE_ADDR, 1'b0});
    put_byte(a);
    put_byte(d);
    stop_cond();
  endtask : reg_write

  // Single byte read, ended with a not-acknowledge
  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    logic b;
    start_cond();
    put_byte({pbes_pkg::PBES_SLAVE_ADDR, 1'b0});
    put_byte(a);
    start_cond();
    put_byte({pbes_pkg::PBES_SLAVE_ADDR, 1'b1});
    for (int i = 7; i >= 0; i--) begin
      get_bit(b);
      d[i] = b;
    end
    put_bit(1'b1);
    stop_cond();
  endtask : reg_read
endmodule : pbes_host_model

// >>> verification/pbes_top_tb.sv
/*
  Self-checking bench: host model on the serial bus, pins from the bench,
  outputs compared as one status vector. Assumes the bound checker.
*/
`timescale 1ns/10ps
module pbes_top_tb;
  localparam int P_EN = 0, P_PROF = 1, P_UV1 = 2, P_UV2 = 3, P_D1 = 4, P_D2 = 5;
  localparam int P_RFB = 6, P_ABV = 7, P_RDONE = 8, P_SS1 = 9, P_SS2 = 10, P_PDB = 12;
  logic clk;
  logic arst_n;
  logic [13:0] pins;
  logic scl, sda, sda_oe;
  logic f1, f2, bst, bck, blk, conv, fst, dis, res, dsen;
  logic [7:0] rd;
  logic [9:0] st;
  logic [7:0] offs [5] = '{8'h06, 8'h07, 8'h09, 8'h41, 8'h20};
  logic [7:0] rst_val [5] = '{8'h00, 8'h00, 8'h00, 8'h06, 8'h00};
  int num_errors = 0;
  int n_compared = 0;

  assign st = {blk, conv, fst, dis, res, dsen, bck, bst, f2, f1};

  pbes_top #(.DEGLITCH_CYCLES(16)) i_dut (
    .core_clk_i(clk), .arst_n_i(arst_n), .ce_i(pins[13]), .fuse_enable_pin_i(pins[0]),
    .profile_select_pin_i(pins[1]), .uvlo_ok_one_i(pins[2]), .uvlo_ok_two_i(pins[3]),
    .loss_detect_one_ok_i(pins[4]), .loss_detect_two_ok_i(pins[5]),
    .release_feedback_ok_i(pins[6]), .storage_above_min_i(pins[7]),
    .release_done_i(pins[8]), .soft_start_done_one_i(pins[9]),
    .soft_start_done_two_i(pins[10]), .power_disable_a_i(pins[11]),
    .power_disable_b_i(pins[12]), .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe),
    .fuse_one_on_o(f1), .fuse_two_on_o(f2), .boost_charge_o(bst), .buck_release_o(bck),
    .blocking_fet_node_on_o(blk), .storage_converter_en_o(conv), .fast_sink_on_o(fst),
    .discharge_transistor_on_o(dis), .resistor_discharge_o(res),
    .downstream_enable_out_o(dsen)
  );

  pbes_host_model i_host (.core_clk_i(clk), .sda_oe_i(sda_oe), .scl_o(scl), .sda_o(sda));

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input string name, input logic [9:0] exp, input logic [9:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : settle

  // Change one pin, wait past sync and deglitch, compare outputs
  task automatic setp(input int idx, input logic v, input logic [9:0] exp);
    @(posedge clk);
    pins[idx] <= v;
    settle(24);
    chk("status", exp, st);
  endtask : setp

  task automatic wrs(input logic [7:0] a, input logic [7:0] d, input logic [9:0] exp);
    i_host.reg_write(a, d);
    settle(4);
    chk("status", exp, st);
  endtask : wrs

  task automatic rdk(input logic [7:0] a, input logic [7:0] exp);
    i_host.reg_read(a, rd);
    chk("register", {2'b00, exp}, {2'b00, rd});
  endtask : rdk

  task automatic final_report();
    $display("Compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report

  // ------------------------------------------------------------
  // Clock, watchdog and sequence
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Run needs about 21000 cycles
  initial begin
    #240000;
    num_errors++;
    final_report();
  end

  initial begin
    pins = 14'h20FC;
    arst_n = 1'b0;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    settle(24);
    chk("status", 10'h040, st);
    for (int i = 0; i < 5; i++) begin
      rdk(offs[i], rst_val[i]);
    end
    wrs(8'h07, 8'hA5, 10'h040);
    rdk(8'h07, 8'hA5);
    wrs(8'h07, 8'h00, 10'h040);
    setp(P_EN, 1'b1, 10'h041);
    wrs(8'h41, 8'h04, 10'h040);
    wrs(8'h41, 8'h06, 10'h041);
    setp(P_UV1, 1'b0, 10'h040);
    setp(P_UV1, 1'b1, 10'h041);
    setp(P_UV2, 1'b0, 10'h041);
    setp(P_PROF, 1'b1, 10'h040);
    setp(P_UV2, 1'b1, 10'h043);
    setp(P_SS1, 1'b1, 10'h043);
    setp(P_SS2, 1'b1, 10'h053);
    wrs(8'h06, 8'h01, 10'h317);
    setp(P_RFB, 1'b0, 10'h313);
    setp(P_RFB, 1'b1, 10'h317);
    setp(P_D2, 1'b0, 10'h31B);
    setp(P_SS1, 1'b0, 10'h31B);
    setp(P_RDONE, 1'b1, 10'h303);
    setp(P_D2, 1'b1, 10'h307);
    setp(P_RDONE, 1'b0, 10'h307);
    setp(P_SS1, 1'b1, 10'h317);
    setp(P_PROF, 1'b0, 10'h315);
    setp(P_D2, 1'b0, 10'h315);
    setp(P_D1, 1'b0, 10'h319);
    setp(P_D1, 1'b1, 10'h319);
    setp(P_RDONE, 1'b1, 10'h315);
    setp(P_RDONE, 1'b0, 10'h315);
    setp(P_EN, 1'b0, 10'h318);
    setp(P_RDONE, 1'b1, 10'h300);
    setp(P_EN, 1'b1, 10'h315);
    setp(P_RDONE, 1'b0, 10'h315);
    wrs(8'h09, 8'h01, 10'h315);
    wrs(8'h41, 8'h07, 10'h315);
    wrs(8'h06, 8'h00, 10'h0D1);
    setp(P_D1, 1'b0, 10'h0D1);
    setp(P_D1, 1'b1, 10'h0D1);
    setp(P_ABV, 1'b0, 10'h051);
    setp(P_ABV, 1'b1, 10'h0D1);
    wrs(8'h06, 8'h01, 10'h315);
    wrs(8'h06, 8'h00, 10'h0D1);
    wrs(8'h07, 8'h01, 10'h051);
    wrs(8'h09, 8'h00, 10'h071);
    wrs(8'h07, 8'h00, 10'h051);
    // Supply loss and return
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    settle(24);
    chk("status", 10'h051, st);
    rdk(8'h06, 8'h00);
    // Short power-disable pulse is ignored, a long one turns the fuse off
    @(posedge clk);
    pins[P_PDB] <= 1'b1;
    repeat (8) @(posedge clk);
    pins[P_PDB] <= 1'b0;
    settle(24);
    chk("status", 10'h051, st);
    setp(P_PDB, 1'b1, 10'h050);
    setp(P_PDB, 1'b0, 10'h051);
    final_report();
  end
endmodule : pbes_top_tb
